// file: dv/qpic_checker.sv
// link checker for both ends of the command port
`timescale 1ns/100ps
`default_nettype none
module qpic_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl_host_o,
  input wire logic scl_host_oe,
  input wire logic sda_host_o,
  input wire logic sda_host_oe,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe,
  input wire logic scl,
  input wire logic sda
);
  logic       scl_q;
  logic       sda_q;
  logic       rd_dir;
  logic       quiet;
  logic [7:0] rises;
  wire        rise  = scl && !scl_q;
  wire        start = scl && scl_q && sda_q && !sda;
  wire        stop  = scl && scl_q && !sda_q && sda;

  always_ff @(posedge clk_i) begin
    scl_q <= scl || rst_i;
    sda_q <= sda || rst_i;
  end

  // clock pulses since start, direction bit, address refused
  always_ff @(posedge clk_i) begin
    if (rst_i || start) begin
      rises  <= 8'h00;
      quiet  <= 1'b0;
      rd_dir <= 1'b0;
    end else if (rise) begin
      rises  <= rises + 8'h01;
      quiet  <= quiet || (rises == 8'h08 && sda);
      rd_dir <= (rises == 8'h07) ? sda : rd_dir;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_scl_low;
    $fell(scl) |-> !scl [*6];
  endproperty
  a_scl_low: assert property (p_scl_low)
    else $error("clock low phase too short");
  property p_dev_steady;
    scl && scl_q |-> $stable(sda_dev_oe);
  endproperty
  a_dev_steady: assert property (p_dev_steady)
    else $error("target moved data while clock high");
  property p_ack_hold;
    rise && sda_dev_oe |-> sda_dev_oe [*8];
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("target let go during high phase");
  property p_start;
    $rose(sda_host_oe) && scl |-> ##[1:20] ($fell(scl) && !sda);
  endproperty
  a_start: assert property (p_start)
    else $error("start not followed by clock low");
  property p_stop_idle;
    $fell(sda_host_oe) && scl |-> (scl && sda) [*4];
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("lines not idle after stop");
  property p_pulse_count;
    stop |-> rises % 9 == 1;
  endproperty
  a_pulse_count: assert property (p_pulse_count)
    else $error("frame not whole nine pulse bytes");
  property p_read_release;
    rise && rd_dir && rises == 8'h11 |-> !sda_dev_oe;
  endproperty
  a_read_release: assert property (p_read_release)
    else $error("target held data at final read ack");
  property p_quiet;
    quiet |-> !sda_dev_oe;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("unaddressed target drove data");
endmodule
`default_nettype wire

// file: dv/tb_quad_pot_i2c_command_port.sv
// bench: controller and target joined over the two-wire link
`timescale 1ns/100ps
`default_nettype none
module tb_quad_pot_i2c_command_port;
  import qpic_pkg::*;
  logic                clk_i;
  logic                rst_i;
  logic                wb_cyc;
  logic                wb_stb;
  logic                wb_we;
  logic [3:0]          wb_adr;
  logic [3:0]          wb_sel;
  logic [31:0]         wb_dat;
  logic [31:0]         wb_rdat;
  logic                wb_ack;
  qpic_strap_t         s_lo;
  qpic_strap_t         s_hi;
  logic                dual;
  logic [NCH-1:0][7:0] wiper;
  logic [NCH-1:0]      sd;
  logic [31:0]         rdat;
  logic [31:0]         seed;
  logic [7:0]          exp_w [NCH];
  logic [7:0]          exp_nvm [NCH];
  logic [NCH-1:0]      exp_sd;
  int                  error_cnt;
  int                  comparisons;

  qpic_if link_if ();
  qpic_ctrl #(.QUARTER(8)) qpic_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .bus(link_if),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack));
  qpic_target #(.STORE_CYC(2000), .RESET_CYC(20)) qpic_target_inst (.clk_i(clk_i),
    .rst_i(rst_i), .bus(link_if), .strap_low_i(s_lo), .strap_high_i(s_hi),
    .dual_strap_i(dual), .wiper_o(wiper), .shutdown_o(sd));
  qpic_checker qpic_checker_inst (.clk_i(clk_i), .rst_i(rst_i),
    .scl_host_o(link_if.scl_host_o), .scl_host_oe(link_if.scl_host_oe),
    .sda_host_o(link_if.sda_host_o), .sda_host_oe(link_if.sda_host_oe),
    .sda_dev_o(link_if.sda_dev_o), .sda_dev_oe(link_if.sda_dev_oe),
    .scl(link_if.scl), .sda(link_if.sda));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [6:0] exp_addr(logic [1:0] lo, logic [1:0] hi);
    return ((lo == 2'h0) ? 7'h20 : (lo == 2'h1) ? 7'h22 : 7'h23)
      + ((hi == 2'h0) ? 7'h00 : (hi == 2'h1) ? 7'h08 : 7'h0c);
  endfunction

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= adr;
    wb_sel <= 4'hf;
    wb_dat <= dat;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    rdat = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (n >= 20) begin
      error_cnt++;
      close_out();
    end
  endtask

  task automatic xfer(input logic [1:0] go, output logic nk);
    int n;
    n = 0;
    wb(1'b1, WB_CTRL, 32'(go));
    do begin
      wb(1'b0, WB_CTRL, 32'h0000_0000);
      n++;
    end while (rdat[STAT_BUSY] !== 1'b0 && n < 3000);
    nk = rdat[STAT_NACK];
    if (n >= 3000) begin
      error_cnt++;
      close_out();
    end
  endtask

  task automatic cmd(input logic [15:0] w, output logic nk);
    wb(1'b1, WB_CMD, 32'(w));
    xfer(2'h1, nk);
  endtask

  task automatic readback(input logic [1:0] ch, input logic [1:0] src, output logic [7:0] b);
    logic nk;
    cmd({CC_READ, 2'b00, ch, 6'h00, src}, nk);
    xfer(2'h2, nk);
    wb(1'b0, WB_RDATA, 32'h0000_0000);
    b = rdat[7:0];
  endtask

  task automatic check_state();
    for (int i = 0; i < NCH; i++) begin
      chk("wiper", 32'(exp_w[i]), 32'(wiper[i]));
    end
    chk("shutdown", 32'(exp_sd), 32'(sd));
  endtask

  task automatic reset_dut(input logic dl, input qpic_strap_t lo, input qpic_strap_t hi);
    @(posedge clk_i);
    dual  <= dl;
    s_lo  <= lo;
    s_hi  <= hi;
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    for (int i = 0; i < NCH; i++) begin
      exp_w[i]   = 8'h80;
      exp_nvm[i] = 8'h80;
    end
    exp_sd = '0;
  endtask

  initial begin
    logic        nk;
    logic [7:0]  b;
    logic [31:0] w;
    logic [1:0]  ch;
    logic [6:0]  ad;
    seed = 32'h0000_be21;
    error_cnt = 0;
    comparisons = 0;
    rst_i = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 4'h0;
    wb_sel = 4'h0;
    wb_dat = 32'h0000_0000;
    dual = 1'b1;
    s_lo = QPIC_STRAP_OPEN;
    s_hi = QPIC_STRAP_OPEN;
    for (int i = 0; i < 12; i++) begin
      reset_dut(i < 9, qpic_strap_t'(i % 3), (i < 9) ? qpic_strap_t'(i / 3) : QPIC_STRAP_GROUND);
      ad = exp_addr(2'(i % 3), (i < 9) ? 2'(i / 3) : 2'h1);
      wb(1'b1, WB_TADDR, 32'(ad));
      cmd(16'h0000, nk);
      chk("address ack", 32'h0000_0000, 32'(nk));
      wb(1'b1, WB_TADDR, 32'(ad ^ 7'h04));
      cmd(16'h0000, nk);
      chk("foreign address", 32'h0000_0001, 32'(nk));
    end
    reset_dut(1'b1, QPIC_STRAP_OPEN, QPIC_STRAP_OPEN);
    wb(1'b0, WB_TADDR, 32'h0000_0000);
    chk("taddr reset", 32'h0000_002a, rdat);
    wb(1'b0, 4'h2, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, rdat);
    check_state();
    wb(1'b1, WB_TADDR, 32'h0000_0000);
    cmd(16'h0000, nk);
    chk("general call", 32'h0000_0001, 32'(nk));
    wb(1'b1, WB_TADDR, 32'h0000_002a);
    $display("test addressing done");
    for (int i = 0; i < 6; i++) begin
      w = rnd();
      ch = w[9:8];
      w[7:0] = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : w[7:0];
      cmd({CC_WIPER, 2'b00, ch, w[7:0]}, nk);
      exp_w[ch] = w[7:0];
      check_state();
      readback(ch, RD_SRC_WIPER, b);
      chk("wiper readback", 32'(exp_w[ch]), 32'(b));
      readback(ch, RD_SRC_NVM, b);
      chk("nvm readback", 32'(exp_nvm[ch]), 32'(b));
      cmd({CC_PRELOAD, 2'b00, ch, ~w[7:0]}, nk);
      check_state();
      cmd({CC_NOP, w[23:12]}, nk);
      check_state();
      cmd({CC_WIPER, 2'b10, ch, ~w[7:0]}, nk);
      check_state();
    end
    $display("test commands done");
    cmd({CC_NVM, 4'h2, 8'h01}, nk);
    exp_nvm[2] = exp_w[2];
    cmd({CC_WIPER, 4'h2, 8'h11}, nk);
    chk("busy refusal", 32'h0000_0001, 32'(nk));
    check_state();
    repeat (2000) @(posedge clk_i);
    cmd({CC_WIPER, 4'h2, ~exp_nvm[2]}, nk);
    exp_w[2] = ~exp_nvm[2];
    readback(2'h2, RD_SRC_NVM, b);
    chk("stored copy", 32'(exp_nvm[2]), 32'(b));
    readback(2'h1, 2'h0, b);
    chk("unlisted source", 32'h0000_0000, 32'(b));
    cmd({CC_NVM, 4'h2, 8'h00}, nk);
    exp_w[2] = exp_nvm[2];
    check_state();
    $display("test nonvolatile done");
    cmd({CC_SHUTDOWN, 4'h1, 8'h01}, nk);
    exp_sd[1] = 1'b1;
    check_state();
    cmd({CC_SHUTDOWN, 4'h8, 8'h01}, nk);
    exp_sd = 4'hf;
    check_state();
    cmd({CC_SHUTDOWN, 4'hb, 8'h00}, nk);
    exp_sd = 4'h0;
    check_state();
    cmd({CC_SHUTDOWN, 4'h3, 8'h01}, nk);
    cmd({CC_WIPER, 4'h0, 8'h3c}, nk);
    cmd({CC_RESET, w[11:0]}, nk);
    repeat (25) @(posedge clk_i);
    for (int i = 0; i < NCH; i++) begin
      exp_w[i] = exp_nvm[i];
    end
    check_state();
    $display("test reset command done");
    close_out();
  end
endmodule
`default_nettype wire

// file: rtl/qpic_ctrl.sv
// two-wire controller end with a classic wishbone register slave
`timescale 1ns/100ps
`default_nettype none
module qpic_ctrl #(
  parameter int unsigned QUARTER = qpic_pkg::QUARTER_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  qpic_if.ctrl             bus,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o
);
  import qpic_pkg::*;

  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_START = 2'b01,
    H_BIT   = 2'b11,
    H_STOP  = 2'b10
  } qpic_hstate_t;

  localparam int unsigned QW = $clog2(QUARTER + 1);

  generate
    if (QUARTER < 8) begin : g_bad_quarter
      $error("qpic_ctrl: QUARTER must be at least 8 cycles");
    end
  endgenerate

  logic sda_s;
  qpic_sync #(.W(1), .INIT(1'b1)) u_sda_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (bus.sda),
    .q_o   (sda_s)
  );

  qpic_hstate_t state;
  logic [15:0]  cmd;
  logic [6:0]   taddr;
  logic [7:0]   rdata;
  logic         nack;
  logic         rd;
  logic         wr_en;
  logic         go;

  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign go    = wr_en && wb_adr_i == WB_CTRL && wb_sel_i[0] && state == H_IDLE
                 && (wb_dat_i[CTRL_GO_WR] || wb_dat_i[CTRL_GO_RD]);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      unique case (wb_adr_i)
        WB_CMD:   wb_dat_o <= {16'h0000, cmd};
        WB_CTRL:  wb_dat_o <= {30'h0000_0000, nack, state != H_IDLE};
        WB_RDATA: wb_dat_o <= {24'h00_0000, rdata};
        WB_TADDR: wb_dat_o <= {25'h000_0000, taddr};
        default:  wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd   <= 16'h0000;
      taddr <= TADDR_RESET;
      rd    <= 1'b0;
    end else if (wr_en && state == H_IDLE) begin
      if (wb_adr_i == WB_CMD && wb_sel_i[0]) cmd[7:0] <= wb_dat_i[7:0];
      if (wb_adr_i == WB_CMD && wb_sel_i[1]) cmd[15:8] <= wb_dat_i[15:8];
      if (wb_adr_i == WB_TADDR && wb_sel_i[0]) taddr <= wb_dat_i[6:0];
      if (go) rd <= wb_dat_i[CTRL_GO_RD];
    end
  end

  // quarter-period ticks pace the link clock
  logic [QW-1:0] qcnt;
  logic          tick;
  logic [1:0]    phase;
  logic [3:0]    bitn;
  logic [1:0]    byten;
  logic [7:0]    rxsh;
  logic          scl_oe;
  logic          sda_oe;
  logic          is_tx;
  logic [7:0]    txb;

  assign tick  = qcnt == QW'(QUARTER - 1);
  assign is_tx = !(rd && byten == 2'h1);
  assign txb   = (byten == 2'h0) ? {taddr, rd} : (byten == 2'h1) ? cmd[15:8] : cmd[7:0];
  assign bus.scl_host_o  = 1'b0;
  assign bus.sda_host_o  = 1'b0;
  assign bus.scl_host_oe = scl_oe;
  assign bus.sda_host_oe = sda_oe;

  always_ff @(posedge clk_i) begin
    if (rst_i || state == H_IDLE || tick) begin
      qcnt <= '0;
    end else begin
      qcnt <= qcnt + QW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state  <= H_IDLE;
      phase  <= 2'h0;
      bitn   <= 4'h0;
      byten  <= 2'h0;
      rxsh   <= 8'h00;
      rdata  <= 8'h00;
      nack   <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else if (state == H_IDLE) begin
      phase <= 2'h0;
      if (go) begin
        state <= H_START;
        nack  <= 1'b0;
      end
    end else if (tick) begin
      phase <= phase + 2'h1;
      unique case (state)
        H_START: begin
          if (phase == 2'h1) sda_oe <= 1'b1;
          if (phase == 2'h2) scl_oe <= 1'b1;
          if (phase == 2'h3) begin
            state <= H_BIT;
            bitn  <= 4'h0;
            byten <= 2'h0;
          end
        end
        H_BIT: begin
          unique case (phase)
            2'h0: sda_oe <= (bitn != BIT_ACK && is_tx) ? !txb[~bitn[2:0]] : 1'b0;
            2'h1: scl_oe <= 1'b0;
            2'h2: begin
              if (bitn != BIT_ACK) rxsh <= {rxsh[6:0], sda_s};
              if (bitn == BIT_ACK && is_tx && sda_s) nack <= 1'b1;
            end
            2'h3: begin
              scl_oe <= 1'b1;
              if (bitn != BIT_ACK) begin
                bitn <= bitn + 4'h1;
              end else if (nack || byten == (rd ? 2'h1 : 2'h2)) begin
                if (!is_tx) rdata <= rxsh;
                state <= H_STOP;
              end else begin
                bitn  <= 4'h0;
                byten <= byten + 2'h1;
              end
            end
          endcase
        end
        H_STOP: begin
          if (phase == 2'h0) sda_oe <= 1'b1;
          if (phase == 2'h1) scl_oe <= 1'b0;
          if (phase == 2'h2) sda_oe <= 1'b0;
          if (phase == 2'h3) state <= H_IDLE;
        end
        H_IDLE: begin
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// file: rtl/qpic_if.sv
// two-wire link between the controller and the potentiometer target
`timescale 1ns/100ps
`default_nettype none
interface qpic_if;
  logic scl_host_o;
  logic scl_host_oe;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic scl;
  logic sda;

  // pulled-up wired-and lines
  assign scl = !(scl_host_oe && !scl_host_o);
  assign sda = !((sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o));

  modport target (input scl, input sda, output sda_dev_o, output sda_dev_oe);
  modport ctrl (input sda, output scl_host_o, output scl_host_oe,
                output sda_host_o, output sda_host_oe);
endinterface
`default_nettype wire

// file: rtl/qpic_pkg.sv
// constants and types shared by both ends of the potentiometer command port
// Summary of operation
// - runs at 100 kHz and 400 kHz
// - seven-bit addresses only, no general call
// - start condition marks the next address byte
// - address byte is seven bits plus direction
// - matching target pulls data low on ninth pulse
// - direction one reads, zero writes
// - mismatch leaves data released until next start
// - nine pulses per byte, msb first, then ack
// - data changes only while clock is low
// - write ends with stop on tenth pulse
// - read ends with controller nack then stop
// - single strap picks one of three addresses
// - two straps pick one of nine addresses
// - word is code, channel, data; zero is nop
// - code one loads the wiper setting
// - code two loads only the preload
// - channel field selects one channel, or all channels for shutdown only
// - refuse commands during nonvolatile store
// - command word assembled from bit fifteen down
// - reset reloads wipers from nonvolatile copy
// - wiper writes also overwrite the preload
package qpic_pkg;
  localparam int unsigned CLK_HZ         = 50_000_000;
  localparam int unsigned SCL_STD_HZ     = 100_000;
  localparam int unsigned SCL_FAST_HZ    = 400_000;
  localparam int unsigned QUARTER_CYCLES = (CLK_HZ + 4 * SCL_FAST_HZ - 1) / (4 * SCL_FAST_HZ);
  localparam int unsigned STORE_MS       = 15;
  localparam int unsigned STORE_CYCLES   = (STORE_MS * (CLK_HZ / 1000) + 0) ;
  localparam int unsigned RESET_US       = 30;
  localparam int unsigned RESET_CYCLES   = (RESET_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int unsigned NCH            = 4;
  localparam int unsigned CMD_CC_LSB     = 12;
  localparam int unsigned CMD_CH_LSB     = 8;
  localparam logic [3:0]  BIT_ACK        = 4'h8;

  typedef enum logic [1:0] {
    QPIC_STRAP_SUPPLY = 2'h0,
    QPIC_STRAP_OPEN   = 2'h1,
    QPIC_STRAP_GROUND = 2'h2
  } qpic_strap_t;

  localparam logic [6:0] ADDR_BASE    = 7'h20;
  localparam logic [6:0] LOW_OFF_OPEN = 7'h02;
  localparam logic [6:0] LOW_OFF_GND  = 7'h03;
  localparam logic [6:0] HI_OFF_OPEN  = 7'h08;
  localparam logic [6:0] HI_OFF_GND   = 7'h0c;

  localparam logic [3:0] CC_NOP      = 4'h0;
  localparam logic [3:0] CC_WIPER    = 4'h1;
  localparam logic [3:0] CC_PRELOAD  = 4'h2;
  localparam logic [3:0] CC_READ     = 4'h3;
  localparam logic [3:0] CC_NVM      = 4'h7;
  localparam logic [3:0] CC_RESET    = 4'hb;
  localparam logic [3:0] CC_SHUTDOWN = 4'hc;
  localparam logic [1:0] RD_SRC_NVM   = 2'h1;
  localparam logic [1:0] RD_SRC_WIPER = 2'h3;
  localparam logic [7:0] WIPER_RESET  = 8'h80;

  localparam logic [3:0] WB_CMD      = 4'h0;
  localparam logic [3:0] WB_CTRL     = 4'h4;
  localparam logic [3:0] WB_RDATA    = 4'h8;
  localparam logic [3:0] WB_TADDR    = 4'hc;
  localparam int unsigned CTRL_GO_WR = 0;
  localparam int unsigned CTRL_GO_RD = 1;
  localparam int unsigned STAT_BUSY  = 0;
  localparam int unsigned STAT_NACK  = 1;
  localparam logic [6:0] TADDR_RESET = 7'h2a;
endpackage

// file: rtl/qpic_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module qpic_sync #(
  parameter int unsigned  W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= INIT;
      q_o  <= INIT;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule
`default_nettype wire

// file: rtl/qpic_target.sv
// potentiometer target: two-wire port and command decoder
`timescale 1ns/100ps
`default_nettype none
module qpic_target #(
  parameter int unsigned STORE_CYC = qpic_pkg::STORE_CYCLES,
  parameter int unsigned RESET_CYC = qpic_pkg::RESET_CYCLES
) (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  qpic_if.target                             bus,
  input  wire qpic_pkg::qpic_strap_t         strap_low_i,
  input  wire qpic_pkg::qpic_strap_t         strap_high_i,
  input  wire logic                          dual_strap_i,
  output logic [qpic_pkg::NCH-1:0][7:0]      wiper_o,
  output logic [qpic_pkg::NCH-1:0]           shutdown_o
);
  import qpic_pkg::*;

  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_ADDR = 3'b001,
    D_ACK  = 3'b011,
    D_RX   = 3'b010,
    D_TX   = 3'b110
  } qpic_dstate_t;

  localparam int unsigned BW = $clog2(STORE_CYC + 1);

  generate
    if (RESET_CYC < 1 || STORE_CYC < RESET_CYC) begin : g_bad_counts
      $error("qpic_target: counts must satisfy 1 <= RESET_CYC <= STORE_CYC");
    end
  endgenerate

  function automatic logic [6:0] strap_addr(input qpic_strap_t lo, input qpic_strap_t hi,
                                            input logic dual);
    logic [6:0] a;
    a = ADDR_BASE;
    unique case (lo)
      QPIC_STRAP_SUPPLY: a = a;
      QPIC_STRAP_OPEN:   a = a | LOW_OFF_OPEN;
      default:           a = a | LOW_OFF_GND;
    endcase
    if (!dual) begin
      a = a | HI_OFF_OPEN;
    end else if (hi == QPIC_STRAP_OPEN) begin
      a = a | HI_OFF_OPEN;
    end else if (hi != QPIC_STRAP_SUPPLY) begin
      a = a | HI_OFF_GND;
    end
    return a;
  endfunction

  function automatic logic [NCH-1:0] ch_mask(input logic [3:0] f, input logic allow_all);
    logic [NCH-1:0] m;
    m = '0;
    if (f[3:2] == 2'b00) begin
      m = NCH'(1) << f[1:0];
    end else if (allow_all && f[3:2] == 2'b10) begin
      m = '1;
    end
    return m;
  endfunction

  // pin sampling; the edge logic handles 100 kHz and 400 kHz alike
  logic [1:0] pins_s;
  logic [4:0] strap_s;
  qpic_sync #(.W(2), .INIT(2'h3)) u_pin_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({bus.scl, bus.sda}),
    .q_o   (pins_s)
  );
  qpic_sync #(.W(5), .INIT(5'h00)) u_strap_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({strap_low_i, strap_high_i, dual_strap_i}),
    .q_o   (strap_s)
  );

  logic       scl_q;
  logic       sda_q;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic [1:0] settle;
  logic       settled;
  logic [6:0] own_addr;

  assign scl_rise  = pins_s[1] && !scl_q;
  assign scl_fall  = !pins_s[1] && scl_q;
  assign start_det = pins_s[1] && scl_q && sda_q && !pins_s[0];
  assign stop_det  = pins_s[1] && scl_q && !sda_q && pins_s[0];
  assign settled   = settle == 2'h3;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= pins_s[1];
      sda_q <= pins_s[0];
    end
  end

  // straps are caught once they have crossed the synchroniser after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      settle <= 2'h0;
    end else if (!settled) begin
      settle <= settle + 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      own_addr <= ADDR_BASE;
    end else if (settle == 2'h2) begin
      own_addr <= strap_addr(qpic_strap_t'(strap_s[4:3]), qpic_strap_t'(strap_s[2:1]),
                             strap_s[0]);
    end
  end

  logic [NCH-1:0][7:0] wiper;
  logic [NCH-1:0][7:0] preload;
  logic [NCH-1:0][7:0] nvm;
  logic [NCH-1:0]      shutdown;
  logic [1:0]          rd_ch;
  logic [1:0]          rd_src;
  logic [7:0]          read_byte;
  logic [BW-1:0]       busy_cnt;
  logic                busy;

  assign busy = busy_cnt != '0;

  always_comb begin
    case (rd_src)
      RD_SRC_NVM:   read_byte = nvm[rd_ch];
      RD_SRC_WIPER: read_byte = wiper[rd_ch];
      default:      read_byte = 8'h00;
    endcase
  end

  qpic_dstate_t state;
  logic [3:0]   bitcnt;
  logic [7:0]   shreg;
  logic [7:0]   cmd_hi;
  logic [1:0]   byte_idx;
  logic         rw;
  logic         sda_oe;
  logic [15:0]  cmd_word;
  logic         cmd_vld;

  assign bus.sda_dev_o  = 1'b0;
  assign bus.sda_dev_oe = sda_oe;

  always_ff @(posedge clk_i) begin
    cmd_vld <= 1'b0;
    if (rst_i) begin
      state    <= D_IDLE;
      bitcnt   <= 4'h0;
      shreg    <= 8'h00;
      cmd_hi   <= 8'h00;
      byte_idx <= 2'h0;
      rw       <= 1'b0;
      sda_oe   <= 1'b0;
      cmd_word <= 16'h0000;
    end else if (start_det) begin
      state    <= D_ADDR;
      bitcnt   <= 4'h0;
      byte_idx <= 2'h0;
      sda_oe   <= 1'b0;
    end else if (stop_det) begin
      state  <= D_IDLE;
      sda_oe <= 1'b0;
    end else if (scl_rise) begin
      unique case (state)
        D_ADDR, D_RX: begin
          shreg  <= {shreg[6:0], pins_s[0]};
          bitcnt <= bitcnt + 4'h1;
        end
        D_TX: begin
          if (bitcnt != BIT_ACK) begin
            bitcnt <= bitcnt + 4'h1;
          end else if (pins_s[0]) begin
            state <= D_IDLE;
          end else begin
            bitcnt <= 4'h0;
            shreg  <= read_byte;
          end
        end
        D_IDLE, D_ACK: begin
        end
      endcase
    end else if (scl_fall) begin
      unique case (state)
        D_ADDR: begin
          if (bitcnt == BIT_ACK) begin
            // seven-bit match only, general call never matches
            if (shreg[7:1] == own_addr && settled && !busy) begin
              state  <= D_ACK;
              sda_oe <= 1'b1;
              rw     <= shreg[0];
            end else begin
              state <= D_IDLE;
            end
          end
        end
        D_RX: begin
          if (bitcnt == BIT_ACK) begin
            if (byte_idx == 2'h0) begin
              cmd_hi   <= shreg;
              byte_idx <= 2'h1;
              state    <= D_ACK;
              sda_oe   <= 1'b1;
            end else if (byte_idx == 2'h1) begin
              cmd_word <= {cmd_hi, shreg};
              cmd_vld  <= 1'b1;
              byte_idx <= 2'h2;
              state    <= D_ACK;
              sda_oe   <= 1'b1;
            end else begin
              state <= D_IDLE;
            end
          end
        end
        D_ACK: begin
          bitcnt <= 4'h0;
          if (rw) begin
            state  <= D_TX;
            shreg  <= read_byte;
            sda_oe <= !read_byte[7];
          end else begin
            state  <= D_RX;
            sda_oe <= 1'b0;
          end
        end
        D_TX: begin
          sda_oe <= (bitcnt == BIT_ACK) ? 1'b0 : !shreg[~bitcnt[2:0]];
        end
        D_IDLE: begin
        end
      endcase
    end
  end

  logic [3:0]     cc;
  logic [3:0]     chf;
  logic [7:0]     dat;
  logic [NCH-1:0] m_one;
  logic [NCH-1:0] m_any;

  assign cc    = cmd_word[CMD_CC_LSB +: 4];
  assign chf   = cmd_word[CMD_CH_LSB +: 4];
  assign dat   = cmd_word[7:0];
  assign m_one = ch_mask(chf, 1'b0);
  assign m_any = ch_mask(chf, 1'b1);

  // a code of CC_NOP or any unlisted code changes nothing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wiper    <= {NCH{WIPER_RESET}};
      preload  <= {NCH{WIPER_RESET}};
      nvm      <= {NCH{WIPER_RESET}};
      shutdown <= '0;
      rd_ch    <= 2'h0;
      rd_src   <= RD_SRC_WIPER;
    end else if (cmd_vld) begin
      for (int i = 0; i < NCH; i++) begin
        if (cc == CC_WIPER && m_one[i]) begin
          wiper[i]   <= dat;
          preload[i] <= dat;
        end
        if (cc == CC_PRELOAD && m_one[i]) begin
          preload[i] <= dat;
        end
        if (cc == CC_NVM && m_one[i]) begin
          if (dat[0]) begin
            nvm[i] <= wiper[i];
          end else begin
            wiper[i]   <= nvm[i];
            preload[i] <= nvm[i];
          end
        end
        if (cc == CC_RESET) begin
          wiper[i]    <= nvm[i];
          preload[i]  <= nvm[i];
          shutdown[i] <= 1'b0;
        end
        if (cc == CC_SHUTDOWN && m_any[i]) begin
          shutdown[i] <= dat[0];
        end
      end
      if (cc == CC_READ && chf[2] == 1'b0) begin
        rd_ch  <= chf[1:0];
        rd_src <= dat[1:0];
      end
    end
  end

  // lockout while storing or resetting
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_cnt <= '0;
    end else if (cmd_vld && cc == CC_NVM && m_one != '0 && dat[0]) begin
      busy_cnt <= BW'(STORE_CYC);
    end else if (cmd_vld && cc == CC_RESET) begin
      busy_cnt <= BW'(RESET_CYC);
    end else if (busy) begin
      busy_cnt <= busy_cnt - BW'(1);
    end
  end

  assign wiper_o    = wiper;
  assign shutdown_o = shutdown;
endmodule
`default_nettype wire
